//--- logic/mibsc_pkg.sv
// mibsc_pkg: offsets, widths, thresholds and reset values of the MIB statistics counters
package mibsc_pkg;
   // counter slots
   localparam int CNT_NUM = 4;
   localparam int IDX_LATE = 0;
   localparam int IDX_PAUSE = 1;
   localparam int IDX_CTRL_TX = 2;
   localparam int IDX_MCAST = 3;

   // register address width and data width
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // register offsets (byte addresses of the register space)
   localparam logic [7:0] OFF_MCAST = 8'hB8;
   localparam logic [7:0] OFF_CTRL_TX = 8'hFA;
   localparam logic [7:0] OFF_LATE = 8'hC0;
   localparam logic [7:0] OFF_PAUSE = 8'hF8;
   localparam logic [3:0][7:0] CNT_OFFSET = {OFF_MCAST, OFF_CTRL_TX, OFF_PAUSE, OFF_LATE};

   // counter widths
   localparam int WIDE_W = 32;
   localparam int NARROW_W = 16;
   localparam int CNT_WIDTH [CNT_NUM] = '{WIDE_W, NARROW_W, NARROW_W, WIDE_W};

   // thresholds that raise the statistics-update event
   localparam logic [31:0] THR_WIDE = 32'hC000_0000;
   localparam logic [31:0] THR_NARROW = 32'h0000_C000;
   localparam logic [31:0] CNT_THRESH [CNT_NUM] = '{THR_WIDE, THR_NARROW, THR_NARROW, THR_WIDE};

   // reset values
   localparam logic [31:0] CNT_RESET = 32'h0000_0000;
   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
   localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;
endpackage : mibsc_pkg

//--- logic/mibsc_counter.sv
// mibsc_counter: one wrapping statistics counter with threshold detection
`timescale 1ns/1ns
module mibsc_counter #(
   parameter int W = 32,
   parameter logic [31:0] THR = 32'h0000_0001
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_inc,
   input wire logic i_wr,
   input wire logic [W-1:0] i_wdata,
   output logic [W-1:0] o_value,
   output logic o_hit
);
   import mibsc_pkg::*;

   // value one below the threshold: the next increment reaches it
   localparam logic [W-1:0] HIT_AT = W'(THR - 32'h0000_0001);

   logic [W-1:0] next_value;

   // software write wins over a same-cycle increment; add wraps at W bits
   always_comb begin
      if (i_wr) begin
         next_value = i_wdata;
      end else if (i_inc) begin
         next_value = o_value + W'(1);
      end else begin
         next_value = o_value;
      end
   end

   // counter storage
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_value <= W'(CNT_RESET);
      end else begin
         o_value <= next_value;
      end
   end

   // single event on the increment that lands on the threshold
   assign o_hit = i_inc && !i_wr && (o_value == HIT_AT);
endmodule : mibsc_counter

//--- logic/mibsc_stats.sv
// mibsc_stats: MAC MIB statistics counter group with register access and update event
`timescale 1ns/1ns
module mibsc_stats (
   input wire logic I_CLK_SYS,
   input wire logic I_RST,
   // control bits held in the MAC control and mask registers
   input wire logic I_GLOBAL_STATS_ENABLE,
   input wire logic [mibsc_pkg::CNT_NUM-1:0] I_PER_COUNTER_MASK,
   // transmit side events
   input wire logic I_TX_COLLISION,
   input wire logic I_TX_SLOT_ELAPSED,
   input wire logic I_TX_CTRL_DONE,
   input wire logic I_TX_CTRL_FROM_HOST,
   // receive control frame events
   input wire logic I_RX_CTRL_DONE,
   input wire logic I_RX_CTRL_PAUSE,
   input wire logic I_RX_CTRL_OK,
   // receive frame status
   input wire logic I_RX_FRAME_DONE,
   input wire logic I_RX_DEST_GROUP,
   input wire logic I_RX_DEST_BCAST,
   input wire logic I_RX_TOO_LONG,
   input wire logic I_RX_FCS_ERR,
   input wire logic I_RX_LEN_ERR,
   input wire logic I_RX_ALIGN_ERR,
   input wire logic I_RX_OVERRUN,
   // register access port
   input wire logic I_REG_WR,
   input wire logic I_REG_RD,
   input wire logic [mibsc_pkg::ADDR_W-1:0] I_REG_ADDR,
   input wire logic [mibsc_pkg::DATA_W-1:0] I_REG_WDATA,
   output logic [mibsc_pkg::DATA_W-1:0] O_REG_RDATA,
   output logic O_REG_RVALID,
   // statistics update event toward the interrupt status register
   output logic O_STATS_THRESHOLD_FLAG
);
   import mibsc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // event qualification

   logic rx_good;
   logic [CNT_NUM-1:0] event_seen;
   logic [CNT_NUM-1:0] cnt_en;
   logic [CNT_NUM-1:0] inc;
   logic [CNT_NUM-1:0] wr_sel;
   logic [CNT_NUM-1:0] rd_sel;
   logic [CNT_NUM-1:0] hit;
   logic [DATA_W-1:0] cnt [CNT_NUM];
   logic [DATA_W-1:0] next_rdata;

   // frame carries none of the excluded error kinds
   assign rx_good = !(I_RX_TOO_LONG || I_RX_FCS_ERR || I_RX_LEN_ERR
                      || I_RX_ALIGN_ERR || I_RX_OVERRUN);

   // raw events per counter slot
   always_comb begin
      event_seen = '0;
      event_seen[IDX_LATE] = I_TX_COLLISION && I_TX_SLOT_ELAPSED;
      event_seen[IDX_PAUSE] = I_RX_CTRL_DONE && I_RX_CTRL_PAUSE && I_RX_CTRL_OK;
      event_seen[IDX_CTRL_TX] = I_TX_CTRL_DONE && !I_TX_CTRL_FROM_HOST;
      event_seen[IDX_MCAST] = I_RX_FRAME_DONE && rx_good && I_RX_DEST_GROUP
                              && !I_RX_DEST_BCAST;
   end

   ////////////////////////////////////////////////////////////////////////////
   // counter bank

   genvar gi;
   generate
      for (gi = 0; gi < CNT_NUM; gi++) begin : g_cnt
         localparam int W = CNT_WIDTH[gi];
         logic [W-1:0] value;

         // gate by global enable and the slot's mask bit
         assign cnt_en[gi] = I_GLOBAL_STATS_ENABLE && !I_PER_COUNTER_MASK[gi];
         assign inc[gi] = event_seen[gi] && cnt_en[gi];
         // address decode for writes and reads
         assign wr_sel[gi] = I_REG_WR && (I_REG_ADDR == CNT_OFFSET[gi]);
         assign rd_sel[gi] = I_REG_RD && (I_REG_ADDR == CNT_OFFSET[gi]);

         // wrapping counter; wrap at W bits
         mibsc_counter #(
            .W(W),
            .THR(CNT_THRESH[gi])
         ) u_counter (
            .i_clk(I_CLK_SYS),
            .i_rst(I_RST),
            .i_inc(inc[gi]),
            .i_wr(wr_sel[gi]),
            .i_wdata(I_REG_WDATA[W-1:0]),
            .o_value(value),
            .o_hit(hit[gi])
         );

         // zero-extend narrow counters on read
         assign cnt[gi] = DATA_W'(value);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // statistics update event

   // one-cycle pulse on any threshold crossing
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         O_STATS_THRESHOLD_FLAG <= 1'b0;
      end else begin
         O_STATS_THRESHOLD_FLAG <= |hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register read path

   // select the addressed counter, unmapped reads give zero
   always_comb begin
      next_rdata = RDATA_UNMAPPED;
      for (int k = 0; k < CNT_NUM; k++) begin
         if (rd_sel[k]) begin
            next_rdata = cnt[k];
         end
      end
   end

   // read data and strobe one cycle after the request
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
         O_REG_RDATA <= RDATA_RESET;
         O_REG_RVALID <= 1'b0;
      end else begin
         O_REG_RDATA <= I_REG_RD ? next_rdata : O_REG_RDATA;
         O_REG_RVALID <= I_REG_RD;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_RST);

   // late collision counts qualified events
   AST_LATE_INC: assert property (
      (I_TX_COLLISION && I_TX_SLOT_ELAPSED && cnt_en[IDX_LATE] && !wr_sel[IDX_LATE])
      |=> cnt[IDX_LATE] == $past(cnt[IDX_LATE]) + 32'h0000_0001)
      else $error("late collision count did not step");

   // early collisions leave the count alone
   AST_LATE_EARLY: assert property (
      (!I_TX_SLOT_ELAPSED && !wr_sel[IDX_LATE]) |=> $stable(cnt[IDX_LATE]))
      else $error("collision within slot time was counted");

   // late collision wrap
   AST_LATE_WRAP: assert property (
      (inc[IDX_LATE] && !wr_sel[IDX_LATE] && cnt[IDX_LATE] == 32'hFFFF_FFFF)
      |=> cnt[IDX_LATE] == 32'h0000_0000)
      else $error("late collision count did not wrap");

   // late collision threshold event
   AST_LATE_FLAG: assert property (
      (inc[IDX_LATE] && !wr_sel[IDX_LATE] && cnt[IDX_LATE] == 32'hBFFF_FFFF)
      |=> O_STATS_THRESHOLD_FLAG && cnt[IDX_LATE] == 32'hC000_0000)
      else $error("late collision threshold missed");

   // disabled statistics freeze every counter
   AST_GATE: assert property (
      (!I_GLOBAL_STATS_ENABLE && !I_REG_WR)
      |=> $stable(cnt[0]) && $stable(cnt[1]) && $stable(cnt[2]) && $stable(cnt[3]))
      else $error("counter moved while statistics disabled");

   // masked slot never steps
   AST_MASK: assert property (
      (I_PER_COUNTER_MASK[IDX_MCAST] && !wr_sel[IDX_MCAST]) |=> $stable(cnt[IDX_MCAST]))
      else $error("masked multicast counter moved");

   // non-pause control frames are ignored
   AST_PAUSE_ONLY: assert property (
      (!I_RX_CTRL_PAUSE && !wr_sel[IDX_PAUSE]) |=> $stable(cnt[IDX_PAUSE]))
      else $error("non-pause control frame counted");

   // pause counter wraps at sixteen bits
   AST_PAUSE_WRAP: assert property (
      (inc[IDX_PAUSE] && !wr_sel[IDX_PAUSE] && cnt[IDX_PAUSE] == 32'h0000_FFFF)
      |=> cnt[IDX_PAUSE] == 32'h0000_0000)
      else $error("pause count did not wrap at 16 bits");

   // pause threshold event
   AST_PAUSE_FLAG: assert property (
      (inc[IDX_PAUSE] && !wr_sel[IDX_PAUSE] && cnt[IDX_PAUSE] == 32'h0000_BFFF)
      |=> O_STATS_THRESHOLD_FLAG)
      else $error("pause threshold missed");

   // own control frames are counted
   AST_CTRL_INC: assert property (
      (I_TX_CTRL_DONE && !I_TX_CTRL_FROM_HOST && cnt_en[IDX_CTRL_TX]
       && !wr_sel[IDX_CTRL_TX])
      |=> cnt[IDX_CTRL_TX] == 32'(16'($past(cnt[IDX_CTRL_TX]) + 32'h0000_0001)))
      else $error("sent control frame not counted");

   // host supplied control frames are not counted
   AST_CTRL_HOST: assert property (
      (I_TX_CTRL_FROM_HOST && !wr_sel[IDX_CTRL_TX]) |=> $stable(cnt[IDX_CTRL_TX]))
      else $error("host control frame counted");

   // sent control threshold event
   AST_CTRL_FLAG: assert property (
      (inc[IDX_CTRL_TX] && !wr_sel[IDX_CTRL_TX] && cnt[IDX_CTRL_TX] == 32'h0000_BFFF)
      |=> O_STATS_THRESHOLD_FLAG)
      else $error("sent control threshold missed");

   // good multicast frames are counted
   AST_MC_INC: assert property (
      (inc[IDX_MCAST] && !wr_sel[IDX_MCAST])
      |=> cnt[IDX_MCAST] == $past(cnt[IDX_MCAST]) + 32'h0000_0001)
      else $error("multicast frame not counted");

   // broadcast and errored frames are not counted
   AST_MC_ERR: assert property (
      ((I_RX_DEST_BCAST || I_RX_FCS_ERR || I_RX_OVERRUN || I_RX_TOO_LONG
        || I_RX_LEN_ERR || I_RX_ALIGN_ERR) && !wr_sel[IDX_MCAST])
      |=> $stable(cnt[IDX_MCAST]))
      else $error("bad or broadcast frame counted as multicast");

   // multicast wrap
   AST_MC_WRAP: assert property (
      (inc[IDX_MCAST] && !wr_sel[IDX_MCAST] && cnt[IDX_MCAST] == 32'hFFFF_FFFF)
      |=> cnt[IDX_MCAST] == 32'h0000_0000)
      else $error("multicast count did not wrap");

   // multicast threshold event
   AST_MC_FLAG: assert property (
      (inc[IDX_MCAST] && !wr_sel[IDX_MCAST] && cnt[IDX_MCAST] == 32'hBFFF_FFFF)
      |=> O_STATS_THRESHOLD_FLAG)
      else $error("multicast threshold missed");

   // flag only follows a crossing increment
   AST_FLAG_ONCE: assert property (
      O_STATS_THRESHOLD_FLAG |-> $past(|hit))
      else $error("update flag without threshold crossing");

   // flag drops when the count sits on the threshold
   AST_FLAG_PULSE: assert property (
      (!(|hit)) |=> !O_STATS_THRESHOLD_FLAG)
      else $error("update flag held without new crossing");

   // late collision needs a collision, not only an elapsed slot
   AST_LATE_NO_COLL: assert property (
      (!I_TX_COLLISION && !wr_sel[IDX_LATE]) |=> $stable(cnt[IDX_LATE]))
      else $error("late collision counted without a collision");

   // masked late collision slot never steps
   AST_LATE_MASK: assert property (
      (I_PER_COUNTER_MASK[IDX_LATE] && !wr_sel[IDX_LATE]) |=> $stable(cnt[IDX_LATE]))
      else $error("masked late collision counter moved");

   // masked pause slot never steps
   AST_PAUSE_MASK: assert property (
      (I_PER_COUNTER_MASK[IDX_PAUSE] && !wr_sel[IDX_PAUSE]) |=> $stable(cnt[IDX_PAUSE]))
      else $error("masked pause counter moved");

   // masked sent control slot never steps
   AST_CTRL_MASK: assert property (
      (I_PER_COUNTER_MASK[IDX_CTRL_TX] && !wr_sel[IDX_CTRL_TX])
      |=> $stable(cnt[IDX_CTRL_TX]))
      else $error("masked sent control counter moved");

   // good pause frames step the sixteen bit count
   AST_PAUSE_INC: assert property (
      (I_RX_CTRL_DONE && I_RX_CTRL_PAUSE && I_RX_CTRL_OK && cnt_en[IDX_PAUSE]
       && !wr_sel[IDX_PAUSE])
      |=> cnt[IDX_PAUSE] == 32'(16'($past(cnt[IDX_PAUSE]) + 32'h0000_0001)))
      else $error("good pause frame not counted");

   // pause frames received with errors are not counted
   AST_PAUSE_BAD: assert property (
      (!I_RX_CTRL_OK && !wr_sel[IDX_PAUSE]) |=> $stable(cnt[IDX_PAUSE]))
      else $error("failed pause frame counted");

   // only finished control frames of our own are counted
   AST_CTRL_IDLE: assert property (
      (!I_TX_CTRL_DONE && !wr_sel[IDX_CTRL_TX]) |=> $stable(cnt[IDX_CTRL_TX]))
      else $error("sent control count moved without a frame");

   // frames to an individual address are not counted as multicast
   AST_MC_SINGLE: assert property (
      (!I_RX_DEST_GROUP && !wr_sel[IDX_MCAST]) |=> $stable(cnt[IDX_MCAST]))
      else $error("individual address frame counted as multicast");

   ////////////////////////////////////////////////////////////////////////////
   // register port checks

   // a write loads the addressed counter and drops any same-cycle event
   AST_WR_LOAD: assert property (
      wr_sel[IDX_MCAST] |=> cnt[IDX_MCAST] == $past(I_REG_WDATA))
      else $error("multicast write did not load");

   // a narrow counter takes only the low half of the write data
   AST_WR_NARROW: assert property (
      wr_sel[IDX_PAUSE] |=> cnt[IDX_PAUSE] == {16'h0000, $past(I_REG_WDATA[15:0])})
      else $error("pause write did not load the low half");

   // every read request gets one valid strobe
   AST_RD_VALID: assert property (
      I_REG_RD |=> O_REG_RVALID)
      else $error("read request without valid strobe");

   // valid strobe only follows a read request
   AST_RD_PULSE: assert property (
      !I_REG_RD |=> !O_REG_RVALID)
      else $error("valid strobe without read request");

   // read data holds between reads
   AST_RD_HOLD: assert property (
      !I_REG_RD |=> $stable(O_REG_RDATA))
      else $error("read data changed without a read");

   // read returns the count before a same-cycle write or event
   AST_RD_LATE: assert property (
      rd_sel[IDX_LATE] |=> O_REG_RDATA == $past(cnt[IDX_LATE]))
      else $error("late collision read returned a wrong value");

   // narrow counters read back zero-extended
   AST_RD_ZEXT: assert property (
      (rd_sel[IDX_PAUSE] || rd_sel[IDX_CTRL_TX]) |=> O_REG_RDATA[31:16] == 16'h0000)
      else $error("narrow counter read with upper bits set");

   // unmapped reads return zero
   AST_RD_UNMAPPED: assert property (
      (I_REG_RD && !(|rd_sel)) |=> O_REG_RDATA == RDATA_UNMAPPED)
      else $error("unmapped read returned nonzero data");

   ////////////////////////////////////////////////////////////////////////////
   // scenarios of interest
   COV_FLAG: cover property (O_STATS_THRESHOLD_FLAG);
   COV_PAUSE: cover property (inc[IDX_PAUSE] ##[1:4] O_REG_RVALID);
   COV_WRAP: cover property (inc[IDX_PAUSE] && cnt[IDX_PAUSE] == 32'h0000_FFFF);
   COV_WR_INC: cover property (inc[IDX_MCAST] && wr_sel[IDX_MCAST]);
endmodule : mibsc_stats

//--- testbench/mibsc_stats_tb_top.sv
// mibsc_stats_tb_top: self-checking bench for the MIB statistics counter group
`timescale 1ns/1ns
module mibsc_stats_tb_top;
   import mibsc_pkg::*;

   // one table row: enable, mask, event bits and which counters should step
   typedef struct packed {
      logic gen;
      logic [3:0] msk;
      logic [14:0] ev;
      logic [3:0] inc;
   } mibsc_row_t;

   // single good event per counter slot: late, pause, ctrl sent, multicast
   localparam logic [14:0] EV_ONE [CNT_NUM] = '{15'h6000, 15'h0700, 15'h1000, 15'h00C0};

   logic I_CLK_SYS = 1'b0;
   logic I_RST = 1'b1;
   logic gen = 1'b0;
   logic [3:0] msk = 4'h0;
   logic [14:0] ev = 15'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic rvalid;
   logic flag;
   logic f_seen;
   logic [31:0] exp_cnt [CNT_NUM];
   int miscompares = 0;
   int cmp_count = 0;

   // rows cover qualifiers, refusals, enable and mask
   mibsc_row_t rows [19] = '{
      '{1'b1, 4'h0, 15'h6000, 4'h1}, '{1'b1, 4'h0, 15'h4000, 4'h0},
      '{1'b1, 4'h0, 15'h1000, 4'h4}, '{1'b1, 4'h0, 15'h1800, 4'h0},
      '{1'b1, 4'h0, 15'h0700, 4'h2}, '{1'b1, 4'h0, 15'h0500, 4'h0},
      '{1'b1, 4'h0, 15'h0600, 4'h0}, '{1'b1, 4'h0, 15'h00C0, 4'h8},
      '{1'b1, 4'h0, 15'h00E0, 4'h0}, '{1'b1, 4'h0, 15'h0080, 4'h0},
      '{1'b1, 4'h0, 15'h00D0, 4'h0}, '{1'b1, 4'h0, 15'h00C8, 4'h0},
      '{1'b1, 4'h0, 15'h00C4, 4'h0}, '{1'b1, 4'h0, 15'h00C2, 4'h0},
      '{1'b1, 4'h0, 15'h00C1, 4'h0}, '{1'b1, 4'h0, 15'h77C0, 4'hF},
      '{1'b0, 4'h0, 15'h77C0, 4'h0}, '{1'b1, 4'h5, 15'h77C0, 4'hA},
      '{1'b1, 4'hA, 15'h77C0, 4'h5}};

   always #25 I_CLK_SYS = ~I_CLK_SYS;

   mibsc_stats dut_u (
      .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST),
      .I_GLOBAL_STATS_ENABLE(gen), .I_PER_COUNTER_MASK(msk),
      .I_TX_COLLISION(ev[14]), .I_TX_SLOT_ELAPSED(ev[13]),
      .I_TX_CTRL_DONE(ev[12]), .I_TX_CTRL_FROM_HOST(ev[11]),
      .I_RX_CTRL_DONE(ev[10]), .I_RX_CTRL_PAUSE(ev[9]), .I_RX_CTRL_OK(ev[8]),
      .I_RX_FRAME_DONE(ev[7]), .I_RX_DEST_GROUP(ev[6]), .I_RX_DEST_BCAST(ev[5]),
      .I_RX_TOO_LONG(ev[4]), .I_RX_FCS_ERR(ev[3]), .I_RX_LEN_ERR(ev[2]),
      .I_RX_ALIGN_ERR(ev[1]), .I_RX_OVERRUN(ev[0]),
      .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
      .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .O_STATS_THRESHOLD_FLAG(flag)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   function automatic logic [31:0] wmask(input int i);
      return (CNT_WIDTH[i] == WIDE_W) ? 32'hFFFF_FFFF : 32'h0000_FFFF;
   endfunction : wmask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(negedge I_CLK_SYS);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge I_CLK_SYS);
      wr = 1'b0;
   endtask : wr_reg

   // read answer lands one cycle after the request edge
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(negedge I_CLK_SYS);
      rd = 1'b1;
      addr = a;
      @(negedge I_CLK_SYS);
      rd = 1'b0;
      chk("rvalid", 32'(rvalid), 32'h0000_0001);
      chk("rdata", rdata, e);
   endtask : rd_chk

   // hold an event for n cycles, then catch the flag of the last edge
   task automatic fire(input logic [14:0] v, input int n);
      @(negedge I_CLK_SYS);
      ev = v;
      repeat (n) @(negedge I_CLK_SYS);
      ev = 15'h0000;
      f_seen = flag;
   endtask : fire

   task automatic wrap_up;
      if (miscompares == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up

   ////////////////////////////////////////////////////////////////////////////////
   // watchdog, far beyond the few hundred cycles the run needs
   initial begin
      #1000000;
      miscompares++;
      wrap_up();
   end

   // main sequence
   initial begin
      repeat (2) @(posedge I_CLK_SYS);
      @(negedge I_CLK_SYS);
      I_RST = 1'b0;
      chk("rvalid idle", 32'(rvalid), 32'h0000_0000);
      chk("flag idle", 32'(flag), 32'h0000_0000);
      for (int i = 0; i < CNT_NUM; i++) begin
         exp_cnt[i] = CNT_RESET;
         rd_chk(CNT_OFFSET[i], CNT_RESET);
      end
      // table of ordinary cases
      foreach (rows[r]) begin
         gen = rows[r].gen;
         msk = rows[r].msk;
         fire(rows[r].ev, 1);
         for (int i = 0; i < CNT_NUM; i++) begin
            if (rows[r].inc[i]) exp_cnt[i] = (exp_cnt[i] + 32'h0000_0001) & wmask(i);
            rd_chk(CNT_OFFSET[i], exp_cnt[i]);
         end
      end
      gen = 1'b1;
      msk = 4'h0;
      // write beats a same-cycle event and raises no flag
      wr_reg(OFF_MCAST, THR_WIDE - 32'h0000_0001);
      @(negedge I_CLK_SYS);
      wr = 1'b1;
      addr = OFF_MCAST;
      wdata = THR_WIDE - 32'h0000_0001;
      ev = EV_ONE[IDX_MCAST];
      @(negedge I_CLK_SYS);
      wr = 1'b0;
      ev = 15'h0000;
      chk("flag on write", 32'(flag), 32'h0000_0000);
      rd_chk(OFF_MCAST, THR_WIDE - 32'h0000_0001);
      // back-to-back events up to threshold, then wrap from all ones
      for (int i = 0; i < CNT_NUM; i++) begin
         wr_reg(CNT_OFFSET[i], CNT_THRESH[i] - 32'h0000_0002);
         fire(EV_ONE[i], 2);
         chk("flag hit", 32'(f_seen), 32'h0000_0001);
         @(negedge I_CLK_SYS);
         chk("flag one cycle", 32'(flag), 32'h0000_0000);
         rd_chk(CNT_OFFSET[i], CNT_THRESH[i]);
         wr_reg(CNT_OFFSET[i], wmask(i));
         fire(EV_ONE[i], 1);
         chk("flag wrap", 32'(f_seen), 32'h0000_0000);
         rd_chk(CNT_OFFSET[i], 32'h0000_0000);
      end
      // pause count passes 0x0FFF without wrapping
      wr_reg(OFF_PAUSE, 32'h0000_0FFF);
      fire(EV_ONE[IDX_PAUSE], 1);
      rd_chk(OFF_PAUSE, 32'h0000_1000);
      // narrow counter keeps low half only of the write data
      wr_reg(OFF_CTRL_TX, 32'hFFFF_1234);
      rd_chk(OFF_CTRL_TX, 32'h0000_1234);
      // read and write in one cycle: the read returns the old value
      @(negedge I_CLK_SYS);
      wr = 1'b1;
      rd = 1'b1;
      addr = OFF_CTRL_TX;
      wdata = 32'h0000_5678;
      @(negedge I_CLK_SYS);
      wr = 1'b0;
      rd = 1'b0;
      chk("rdata old", rdata, 32'h0000_1234);
      rd_chk(OFF_CTRL_TX, 32'h0000_5678);
      wr_reg(8'h00, 32'hFFFF_FFFF);
      rd_chk(8'h00, RDATA_UNMAPPED);
      rd_chk(OFF_PAUSE, 32'h0000_1000);
      // valid strobe stands for one cycle only
      @(negedge I_CLK_SYS);
      chk("rvalid one cycle", 32'(rvalid), 32'h0000_0000);
      // second reset in mid-run clears the counters
      @(negedge I_CLK_SYS);
      I_RST = 1'b1;
      @(negedge I_CLK_SYS);
      I_RST = 1'b0;
      chk("rdata reset", rdata, RDATA_RESET);
      chk("rvalid reset", 32'(rvalid), 32'h0000_0000);
      chk("flag reset", 32'(flag), 32'h0000_0000);
      rd_chk(OFF_PAUSE, CNT_RESET);
      rd_chk(OFF_CTRL_TX, CNT_RESET);
      wrap_up();
   end
endmodule : mibsc_stats_tb_top
